// [inc/core_reg_seq_pkg.sv]
package core_reg_seq_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFF_CTRL   = 8'h00;  // Control: flash power in sleep, sleep request
    localparam logic [7:0] OFF_CONFIG = 8'h04;  // Config word 3 image
    localparam logic [7:0] OFF_STATUS = 8'h08;  // Sticky event flags, read clears
    localparam logic [7:0] OFF_MASK   = 8'h0C;  // Interrupt mask
    localparam logic [7:0] OFF_STATE  = 8'h10;  // Live state

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL_FLASH_PWR_BIT  = 8;    // Flash power in sleep
    localparam int CTRL_SLEEP_BIT      = 0;    // Write 1 enters sleep
    localparam int CFG_WUT_LSB         = 10;   // Wake-up time select
    localparam int STAT_BROWNOUT_BIT   = 1;    // Brown-out reset flag
    localparam int STAT_LVD_BIT        = 8;    // Low-voltage detect flag
    localparam int STATE_HOLD_BIT      = 0;    // Core hold
    localparam int STATE_SLEEP_BIT     = 1;    // Asleep
    localparam int STATE_FLASH_OFF_BIT = 2;    // Flash unpowered
    localparam int STATE_REG_EN_BIT    = 3;    // Regulator enabled

    // ==========================================================
    // Reset values and encodings
    // ==========================================================
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [1:0]  WUT_FAST     = 2'h1;  // Fast wake-up code

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ       = 125;
    localparam int T_STARTUP_US  = 10;      // Regulator start-up hold
    localparam int T_LEGACY_US   = 190;     // Legacy standby wake-up
    localparam int T_PWRUP_MS    = 64;      // Power-up delay timer
    localparam int STARTUP_CYC   = T_STARTUP_US * CLK_MHZ;
    localparam int LEGACY_CYC    = T_LEGACY_US * CLK_MHZ;
    localparam int PWRUP_CYC     = T_PWRUP_MS * 1000 * CLK_MHZ;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } seq_state_t;

endpackage : core_reg_seq_pkg

// [rtl/hold_counter.sv]
`timescale 1ns/1ns
// Loadable down-counter; done stays high while count is zero and no load is applied
module hold_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_q;   // Remaining cycles

    // ==========================================================
    // Counter
    // ==========================================================
    // Load wins over counting; sits at zero when finished
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    assign done = (cnt_q == '0) && !load;

endmodule : hold_counter

// [rtl/core_regulator_power_sequencer.sv]
`timescale 1ns/1ns
module core_regulator_power_sequencer #(
    parameter int PWRUP_CYCLES = core_reg_seq_pkg::PWRUP_CYC,  // Shorten in simulation
    parameter int CNT_W        = 24
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        regulator_disable_strap,
    input  wire logic        supply_below_full_speed,
    input  wire logic        regulator_input_low,
    input  wire logic        wake_event,
    output logic             core_hold,
    output logic             regulator_enable,
    output logic             flash_power_off,
    output logic             brownout_reset_req,
    output logic             irq
);
    // ==========================================================
    // Declarations
    // ==========================================================
    core_reg_seq_pkg::seq_state_t state_q;      // Sequencer state
    logic              reg_en_q;                // Strap captured after reset
    logic              first_q;                 // Cold start pending
    logic              bor_start_q;             // Start after brown-out
    logic [31:0]       ctrl_q;                  // Control register
    logic [31:0]       config_q;                // Config word 3 image
    logic [31:0]       mask_q;                  // Interrupt mask
    logic              lvd_q;                   // Low-voltage flag
    logic              bor_q;                   // Brown-out flag
    logic              wr_pend_q;               // Write data phase pending
    logic              rd_pend_q;               // Read data phase pending
    logic [7:0]        addr_q;                  // Latched address
    logic              load;                    // Counter load strobe
    logic [CNT_W-1:0]  load_val;                // Counter load value
    logic              cnt_done;                // Hold elapsed
    logic              flash_pwr;               // Flash power in sleep bit
    logic [1:0]        wut_sel;                 // Wake-up time select
    logic              sleep_req;               // Software sleep request
    logic              ap_valid;                // Valid address phase
    logic              lvd_set;                 // Flag set event
    logic              bor_set;                 // Brown-out event
    logic              stat_rd;                 // Status read clears
    logic [31:0]       status;                  // Status image
    logic [31:0]       state_img;               // State image

    localparam logic [CNT_W-1:0] STARTUP_LD = CNT_W'(core_reg_seq_pkg::STARTUP_CYC);
    localparam logic [CNT_W-1:0] LEGACY_LD  = CNT_W'(core_reg_seq_pkg::LEGACY_CYC);
    localparam logic [CNT_W-1:0] PWRUP_LD   = CNT_W'(PWRUP_CYCLES);

    assign flash_pwr = ctrl_q[core_reg_seq_pkg::CTRL_FLASH_PWR_BIT];
    assign wut_sel   = config_q[core_reg_seq_pkg::CFG_WUT_LSB +: 2];
    assign ap_valid  = hsel && hready && htrans[1];
    assign sleep_req = wr_pend_q && (addr_q == core_reg_seq_pkg::OFF_CTRL)
                       && hwdata[core_reg_seq_pkg::CTRL_SLEEP_BIT];

    // ==========================================================
    // Strap capture
    // ==========================================================
    // Strap sampled by clock after reset release, stays fixed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_en_q <= 1'b0;
            first_q  <= 1'b1;
        end else if (first_q) begin
            reg_en_q <= !regulator_disable_strap;
            first_q  <= 1'b0;
        end
    end

    assign regulator_enable = reg_en_q;

    // ==========================================================
    // Hold timing
    // ==========================================================
    // Wake hold length chosen from config field and flash bit
    always_comb begin
        load     = 1'b0;
        load_val = STARTUP_LD;
        if (first_q) begin
            // Cold start: regulator path or power-up timer
            load     = 1'b1;
            load_val = !regulator_disable_strap ? STARTUP_LD : PWRUP_LD;
        end else if (bor_start_q) begin
            load     = 1'b1;
            load_val = reg_en_q ? STARTUP_LD : PWRUP_LD;
        end else if (state_q == core_reg_seq_pkg::ST_SLEEP && wake_event) begin
            load = 1'b1;
            if (flash_pwr) begin
                load_val = CNT_W'(0);
            end else if (wut_sel == core_reg_seq_pkg::WUT_FAST) begin
                load_val = STARTUP_LD;
            end else begin
                load_val = LEGACY_LD;
            end
        end
    end

    hold_counter #(
        .WIDTH (CNT_W)
    ) u_hold (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (load),
        .value   (load_val),
        .done    (cnt_done)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Hold -> run -> sleep -> hold; brown-out forces hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= core_reg_seq_pkg::ST_HOLD;
            bor_start_q <= 1'b0;
        end else begin
            bor_start_q <= bor_set;
            case (state_q)
                core_reg_seq_pkg::ST_HOLD: begin
                    // A brown-out arriving as the hold ends keeps the core held
                    if (cnt_done && !first_q && !bor_start_q && !bor_set) begin
                        state_q <= core_reg_seq_pkg::ST_RUN;
                    end
                end
                core_reg_seq_pkg::ST_RUN: begin
                    if (bor_set) begin
                        state_q <= core_reg_seq_pkg::ST_HOLD;
                    end else if (sleep_req) begin
                        state_q <= core_reg_seq_pkg::ST_SLEEP;
                    end
                end
                core_reg_seq_pkg::ST_SLEEP: begin
                    if (bor_set || wake_event) begin
                        state_q <= core_reg_seq_pkg::ST_HOLD;
                    end
                end
                default: state_q <= core_reg_seq_pkg::ST_HOLD;
            endcase
        end
    end

    assign core_hold       = (state_q != core_reg_seq_pkg::ST_RUN);
    assign flash_power_off = (state_q == core_reg_seq_pkg::ST_SLEEP) && !flash_pwr;
    assign bor_set         = reg_en_q && !first_q && regulator_input_low;
    assign brownout_reset_req = bor_set;
    assign lvd_set         = reg_en_q && !first_q && supply_below_full_speed;

    // ==========================================================
    // Bus slave
    // ==========================================================
    // Latch address phase; always zero wait, OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= ap_valid && hwrite;
            rd_pend_q <= ap_valid && !hwrite;
            if (ap_valid) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign stat_rd   = rd_pend_q && (addr_q == core_reg_seq_pkg::OFF_STATUS);

    // Writable registers; sleep bit self-clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= core_reg_seq_pkg::CTRL_RESET;
            config_q <= core_reg_seq_pkg::CONFIG_RESET;
            mask_q   <= core_reg_seq_pkg::MASK_RESET;
        end else if (wr_pend_q) begin
            case (addr_q)
                core_reg_seq_pkg::OFF_CTRL: ctrl_q <= hwdata & 32'h0000_0100;
                core_reg_seq_pkg::OFF_CONFIG: config_q <= hwdata & 32'h0000_0C00;
                core_reg_seq_pkg::OFF_MASK: mask_q <= hwdata & 32'h0000_0102;
                default: ;
            endcase
        end
    end

    // Sticky flags: set wins over read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvd_q <= 1'b0;
            bor_q <= 1'b0;
        end else begin
            lvd_q <= lvd_set || (lvd_q && !stat_rd);
            bor_q <= bor_set || (bor_q && !stat_rd);
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[core_reg_seq_pkg::STAT_LVD_BIT]      = lvd_q;
        status[core_reg_seq_pkg::STAT_BROWNOUT_BIT] = bor_q;
        state_img = 32'h0000_0000;
        state_img[core_reg_seq_pkg::STATE_HOLD_BIT]      = core_hold;
        state_img[core_reg_seq_pkg::STATE_SLEEP_BIT]     = (state_q == core_reg_seq_pkg::ST_SLEEP);
        state_img[core_reg_seq_pkg::STATE_FLASH_OFF_BIT] = flash_power_off;
        state_img[core_reg_seq_pkg::STATE_REG_EN_BIT]    = reg_en_q;
    end

    // Read data from a flop, loaded at address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            case (haddr[7:0])
                core_reg_seq_pkg::OFF_CTRL:   hrdata <= ctrl_q;
                core_reg_seq_pkg::OFF_CONFIG: hrdata <= config_q;
                core_reg_seq_pkg::OFF_STATUS: hrdata <= status;
                core_reg_seq_pkg::OFF_MASK:   hrdata <= mask_q;
                core_reg_seq_pkg::OFF_STATE:  hrdata <= state_img;
                default:                      hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign irq = |(status & mask_q);

    // ==========================================================
    // Assertions
    // ==========================================================
    a_lvd_gated: assert property (@(posedge hclk) disable iff (!hresetn)
        !reg_en_q |-> !lvd_q)
        else $error("low voltage flag set with regulator off");
    a_lvd_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        lvd_set |=> lvd_q)
        else $error("low voltage flag not set");
    a_bor_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        bor_set |=> bor_q && core_hold)
        else $error("brown-out not recorded");
    a_strap_map: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(first_q) |-> reg_en_q == !$past(regulator_disable_strap))
        else $error("regulator enable does not follow strap");
    a_flash_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == core_reg_seq_pkg::ST_SLEEP && !flash_pwr) |-> flash_power_off)
        else $error("flash powered in standby sleep");
    a_fast_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && state_q == core_reg_seq_pkg::ST_SLEEP && !flash_pwr
         && wut_sel == core_reg_seq_pkg::WUT_FAST) |-> load_val == STARTUP_LD)
        else $error("fast wake hold wrong");
    a_legacy_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && state_q == core_reg_seq_pkg::ST_SLEEP && !flash_pwr
         && wut_sel != core_reg_seq_pkg::WUT_FAST) |-> load_val == LEGACY_LD)
        else $error("legacy wake hold wrong");
    a_nohold_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == core_reg_seq_pkg::ST_SLEEP && wake_event && flash_pwr && !bor_set)
        |=> ##1 !core_hold)
        else $error("wake held with flash powered");
    a_hold_min: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == core_reg_seq_pkg::ST_SLEEP && wake_event && !flash_pwr)
        |=> core_hold [*8])
        else $error("wake hold too short");

    c_sleep: cover property (@(posedge hclk) state_q == core_reg_seq_pkg::ST_SLEEP);
    c_wake:  cover property (@(posedge hclk) state_q == core_reg_seq_pkg::ST_SLEEP && wake_event);
    c_bor:   cover property (@(posedge hclk) bor_set);
    c_irq:   cover property (@(posedge hclk) irq);

endmodule : core_regulator_power_sequencer

// [testbench/core_regulator_power_sequencer_tb.sv]
`timescale 1ns/1ns
module core_regulator_power_sequencer_tb;
    // ==========================================================
    // Bench settings
    // ==========================================================
    localparam int PWRUP = 2000;                           // Shortened power-up delay
    localparam int SU    = core_reg_seq_pkg::STARTUP_CYC;  // Start-up hold cycles
    localparam int LEG   = core_reg_seq_pkg::LEGACY_CYC;   // Legacy wake cycles
    localparam int TOL   = 4;                              // Slack on hold lengths
    localparam int LIM   = 30000;                          // Bound on hold waits

    // ==========================================================
    // Signals
    // ==========================================================
    logic        hclk, hresetn, hsel, hwrite;              // Clock, reset, bus control
    logic [31:0] haddr, hwdata, hrdata;                    // Bus address and data
    logic [1:0]  htrans;                                   // Transfer type
    logic [2:0]  hsize;                                    // Transfer size
    logic        hreadyout, hresp;                         // Slave answer
    logic        strap, sup_low, reg_in_low, wake;         // Pin stimulus
    logic        core_hold, regulator_enable, flash_power_off, brownout_reset_req, irq;
    int          error_cnt, checks, seed, n;               // Counters and seed
    logic [31:0] rd;                                       // Read scratch

    core_regulator_power_sequencer #(.PWRUP_CYCLES(PWRUP)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .regulator_disable_strap(strap), .supply_below_full_speed(sup_low),
        .regulator_input_low(reg_in_low), .wake_event(wake), .core_hold(core_hold),
        .regulator_enable(regulator_enable), .flash_power_off(flash_power_off),
        .brownout_reset_req(brownout_reset_req), .irq(irq));

    // Free-running 125 MHz clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    // Closing report and verdict
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    // Exact compare of a value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
        end
    endtask : chk

    // Length compare within slack
    task automatic chk_len(input int got, input int exp, input string m);
        checks++;
        if (got < exp - TOL || got > exp + TOL) begin
            error_cnt++;
            $display("unexpected at %0t: %s length %0d want %0d", $time, m, got, exp);
        end
    endtask : chk_len

    // Bounded wait ran out
    task automatic timeout(input string m);
        error_cnt++;
        $display("unexpected at %0t: timeout %s", $time, m);
        test_done();
    endtask : timeout

    // One AHB-Lite single transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        int k;
        k = 0;
        hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'b10; hwrite <= wr;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) timeout("address phase");
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) timeout("data phase");
        rdat = hrdata;
    endtask : bus

    // Count cycles while the core is held
    task automatic hold_len(output int c);
        c = 0;
        while (core_hold === 1'b1 && c < LIM) begin @(posedge hclk); c++; end
        if (c >= LIM) timeout("core hold");
    endtask : hold_len

    // Expected wake hold for field and flash bit
    function automatic int exp_wake(input logic [1:0] sel, input logic fl);
        if (fl) return 2;
        return (sel == core_reg_seq_pkg::WUT_FAST) ? SU : LEG;
    endfunction : exp_wake

    // Reset with a given strap, then time the start-up hold
    task automatic do_reset(input logic s, input int exp);
        hresetn <= 1'b0; strap <= s;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        hold_len(n);
        chk_len(n, exp, "start-up hold");
        chk(regulator_enable, !s, "regulator enable");
    endtask : do_reset

    // Sleep, idle a random while, wake, time the hold
    task automatic sleep_wake(input logic fl, input logic [1:0] sel);
        bus(1'b1, core_reg_seq_pkg::OFF_CONFIG, {20'h0_0000, sel, 10'h000}, rd);
        bus(1'b1, core_reg_seq_pkg::OFF_CTRL, {23'h00_0000, fl, 8'h01}, rd);
        repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge hclk);
        chk(flash_power_off, !fl, "flash off in sleep");
        bus(1'b0, core_reg_seq_pkg::OFF_STATE, 32'h0000_0000, rd);
        chk(rd[core_reg_seq_pkg::STATE_SLEEP_BIT], 1'b1, "asleep");
        wake <= 1'b1;
        @(posedge hclk);
        wake <= 1'b0;
        hold_len(n);
        chk_len(n, exp_wake(sel, fl), "wake hold");
        chk(flash_power_off, 1'b0, "flash on after wake");
        $display("test sleep flash %0d sel %0d done", fl, sel);
    endtask : sleep_wake

    // Supply dip of random length, then status read and clear
    task automatic lvd_pulse(input logic [31:0] exp, input logic exp_irq);
        sup_low <= 1'b1;
        repeat (1 + ($unsigned($random(seed)) % 8)) @(posedge hclk);
        sup_low <= 1'b0;
        @(posedge hclk);
        chk(irq, exp_irq, "irq level");
        bus(1'b0, core_reg_seq_pkg::OFF_STATUS, 32'h0000_0000, rd);
        chk(rd, exp, "status after dip");
        bus(1'b0, core_reg_seq_pkg::OFF_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "status cleared by read");
        chk(irq, 1'b0, "irq cleared");
    endtask : lvd_pulse

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        error_cnt = 0; checks = 0; seed = 45951;
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000; htrans = 2'b00; hsize = 3'h2;
        strap = 1'b0; sup_low = 1'b0; reg_in_low = 1'b0; wake = 1'b0;
        @(posedge hclk);
        // Regulator enabled: start-up hold, reset values
        do_reset(1'b0, SU);
        bus(1'b0, core_reg_seq_pkg::OFF_CTRL, 32'h0000_0000, rd);
        chk(rd, core_reg_seq_pkg::CTRL_RESET, "ctrl reset");
        bus(1'b0, core_reg_seq_pkg::OFF_CONFIG, 32'h0000_0000, rd);
        chk(rd, core_reg_seq_pkg::CONFIG_RESET, "config reset");
        bus(1'b0, core_reg_seq_pkg::OFF_MASK, 32'h0000_0000, rd);
        chk(rd, core_reg_seq_pkg::MASK_RESET, "mask reset");
        bus(1'b0, 8'h40, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk(hresp, 1'b0, "okay response");
        $display("test reset enabled done");
        // Low-voltage detect, masked then unmasked
        lvd_pulse(32'h1 << core_reg_seq_pkg::STAT_LVD_BIT, 1'b0);
        bus(1'b1, core_reg_seq_pkg::OFF_MASK, 32'h0000_0100, rd);
        lvd_pulse(32'h0000_0100, 1'b1);
        $display("test low voltage done");
        // Brown-out while running
        reg_in_low <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(brownout_reset_req, 1'b1, "brown-out request");
        chk(core_hold, 1'b1, "held in brown-out");
        reg_in_low <= 1'b0;
        @(posedge hclk);
        hold_len(n);
        chk_len(n, SU, "hold after brown-out");
        bus(1'b0, core_reg_seq_pkg::OFF_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0002, "brown-out flag");
        $display("test brown-out done");
        // Sleep and wake cases, regulator enabled
        sleep_wake(1'b0, 2'b00);
        sleep_wake(1'b0, 2'b01);
        sleep_wake(1'b1, 2'b00);
        // Regulator disabled: power-up timer, no detection, no brown-out
        do_reset(1'b1, PWRUP);
        bus(1'b1, core_reg_seq_pkg::OFF_MASK, 32'h0000_0102, rd);
        lvd_pulse(32'h0000_0000, 1'b0);
        reg_in_low <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(brownout_reset_req, 1'b0, "no brown-out when off");
        chk(core_hold, 1'b0, "core runs");
        reg_in_low <= 1'b0;
        @(posedge hclk);
        bus(1'b0, core_reg_seq_pkg::OFF_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "no flag when off");
        $display("test regulator disabled done");
        sleep_wake(1'b0, 2'b00);
        sleep_wake(1'b1, 2'b01);
        test_done();
    end
endmodule : core_regulator_power_sequencer_tb
